// >>> sleep_pkg.sv
// Shared constants and types for the sleep and wake controller
package sleep_pkg;

  // Bus geometry
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;

  // Register byte offsets
  localparam logic [7:0] OFF_CTRL     = 8'h00;
  localparam logic [7:0] OFF_STATUS   = 8'h04;
  localparam logic [7:0] OFF_WAKE_EN  = 8'h08;
  localparam logic [7:0] OFF_IRQ_STS  = 8'h0C;
  localparam logic [7:0] OFF_IRQ_MASK = 8'h10;
  localparam logic [7:0] OFF_WDT_CNT  = 8'h14;

  // Control register layout
  localparam int CTRL_W         = 8;
  localparam int CTRL_GIE       = 0;
  localparam int CTRL_WDT_EN    = 1;
  localparam int CTRL_WDT_SLEEP = 2;
  localparam int CTRL_MASTER_CLEAR_PIN_EN   = 3;
  localparam int CTRL_BOR_EN    = 4;
  localparam int CTRL_T1SRC_LO  = 5;
  localparam int CTRL_T1SRC_HI  = 6;
  localparam int CTRL_ADC_RC    = 7;
  localparam logic [CTRL_W-1:0] CTRL_RST = 8'h00;

  // Timer1 clock source codes
  localparam logic [1:0] T1SRC_SYS   = 2'h0;
  localparam logic [1:0] T1SRC_LFOSC = 2'h1;
  localparam logic [1:0] T1SRC_PIN   = 2'h2;
  localparam logic [1:0] T1SRC_SOSC  = 2'h3;

  // Core status register layout and reset values
  localparam int STS_PD       = 0;
  localparam int STS_TO       = 1;
  localparam int STS_ASLEEP   = 2;
  localparam int STS_RESUMING = 3;
  localparam logic PD_RST = 1'b1;
  localparam logic TO_RST = 1'b1;

  // Interrupt event bits
  localparam int EV_W        = 4;
  localparam int EV_SLEEP    = 0;
  localparam int EV_WAKE_INT = 1;
  localparam int EV_WAKE_WDT = 2;
  localparam int EV_RESET    = 3;
  localparam logic [EV_W-1:0] EV_RST = 4'h0;

  // Power states
  typedef enum logic [2:0] {
    ST_RUN   = 3'b001,
    ST_SLEEP = 3'b010,
    ST_NEXT  = 3'b100
  } pwr_state_t;

endpackage : sleep_pkg

// >>> wake_if.sv
// Interface carrying wake sources between controller and qualifier
`timescale 1ns/1ps
interface wake_if #(
  parameter int N_INT = 8
);
  logic [N_INT-1:0] src_flag;
  logic [N_INT-1:0] src_en;
  logic             wake_int;
  logic [N_INT-1:0] live_src;

  modport ctrl (output src_flag, output src_en, input wake_int, input live_src);
  modport qual (input src_flag, input src_en, output wake_int, output live_src);
endinterface : wake_if

// >>> wake_qualifier.sv
// Qualifies interrupt wake sources by their individual enables
`timescale 1ns/1ps
module wake_qualifier #(
  parameter int N_INT = 8
) (
  wake_if.qual w
);

  // Only enabled sources may wake; global enable plays no part here
  assign w.live_src = w.src_flag & w.src_en;   // [R14]
  assign w.wake_int = |w.live_src;             // [R19]

endmodule : wake_qualifier

// >>> sleep_wake_controller.sv
// Sleep entry, wake and resume sequencing with an APB register slave
`timescale 1ns/1ps

// Behaviour
// [R01] Sleep is entered only when the core executes the sleep instruction.
// [R02] Entering sleep clears the watchdog; it keeps counting if enabled for sleep.
// [R03] Entering sleep clears the power-down flag.
// [R04] Entering sleep sets the watchdog-expiry flag.
// [R05] CPU clock is gated off while asleep.
// [R06] Low-frequency internal oscillator keeps running during sleep.
// [R07] Timer1 runs in sleep on low-freq, pin or secondary oscillator clock.
// [R08] Converter runs in sleep when its dedicated RC clock is selected.
// [R09] I/O pins hold their pre-sleep drive state while asleep.
// [R10] Resets other than the watchdog behave the same asleep or awake.
// [R11] Wake on master-clear, brown-out, power-on, watchdog or enabled interrupt.
// [R12] Pin, brown-out, power-on resets fully reset; others resume execution.
// [R13] The instruction after the sleep instruction is prefetched.
// [R14] Interrupt wakes only if its own enable is set, regardless of global.
// [R15] Wake with global disabled resumes after sleep, without vectoring.
// [R16] Wake with global enabled runs next instruction, then calls the handler.
// [R17] Software places a no-op after sleep when the next instruction is unwanted.
// [R18] Every exit from sleep clears the watchdog.
// [R19] Wake is the OR of qualified sources; CPU clock restarts synchronously.
module sleep_wake_controller
  import sleep_pkg::*;
#(
  parameter int N_INT  = 8,
  parameter int PC_W   = 15,
  parameter int PIN_W  = 8,
  parameter int WDT_W  = 16,
  parameter int WDT_LIMIT = 1024
) (
  input  wire logic                       clk,
  input  wire logic                       rstn,
  input  wire logic                       ce,
  // APB slave
  input  wire logic                       psel,
  input  wire logic                       penable,
  input  wire logic                       pwrite,
  input  wire logic [sleep_pkg::ADDR_W-1:0] paddr,
  input  wire logic [sleep_pkg::DATA_W-1:0] pwdata,
  output logic      [sleep_pkg::DATA_W-1:0] prdata,
  output logic                            pready,
  output logic                            pslverr,
  // CPU core
  input  wire logic                       sleep_exec,
  input  wire logic [PC_W-1:0]            cpu_pc,
  input  wire logic                       instr_retired,
  output logic                            cpu_clk_en,
  output logic                            prefetch_req,
  output logic      [PC_W-1:0]            prefetch_addr,
  output logic                            isr_call,
  // Wake and reset sources
  input  wire logic [N_INT-1:0]           int_flag,
  input  wire logic                       lf_tick,
  input  wire logic                       master_clear_pin,
  input  wire logic                       brownout_reset,
  output logic                            device_reset_req,
  output logic                            watchdog_reset_req,
  // Clock domains kept alive in sleep
  output logic                            low_freq_internal_osc_run,
  output logic                            timer1_run,
  output logic                            adc_run,
  // Pin drive hold
  input  wire logic [PIN_W-1:0]           pin_out_in,
  input  wire logic [PIN_W-1:0]           pin_oe_in,
  output logic      [PIN_W-1:0]           pin_out,
  output logic      [PIN_W-1:0]           pin_oe,
  output logic                            irq
);

  // Reset synchroniser: async assert, two-flop release
  logic rst_meta_ff;
  logic rst_sync_ff;
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rst_meta_ff <= 1'b0;
      rst_sync_ff <= 1'b0;
    end else begin
      rst_meta_ff <= 1'b1;
      rst_sync_ff <= rst_meta_ff;
    end
  end
  wire logic srst_n = rst_sync_ff;

  // Registers and state
  pwr_state_t              state_ff;
  pwr_state_t              nxt_state;
  logic [CTRL_W-1:0]       ctrl_ff;
  logic [N_INT-1:0]        wake_en_ff;
  logic [EV_W-1:0]         irq_sts_ff;
  logic [EV_W-1:0]         irq_mask_ff;
  logic                    pd_flag_ff;
  logic                    to_flag_ff;
  logic [WDT_W-1:0]        wdt_cnt_ff;
  logic [DATA_W-1:0]       prdata_ff;
  logic                    prefetch_ff;
  logic [PC_W-1:0]         prefetch_addr_ff;
  logic                    isr_call_ff;
  logic                    dev_rst_ff;
  logic                    wdt_rst_ff;
  logic [PIN_W-1:0]        pin_out_ff;
  logic [PIN_W-1:0]        pin_oe_ff;

  // Wake source qualification
  wake_if #(.N_INT(N_INT)) wk ();
  assign wk.src_flag = int_flag;
  assign wk.src_en   = wake_en_ff;
  wake_qualifier #(.N_INT(N_INT)) u_qual (
    .w (wk.qual)
  );

  // Control field decode
  wire logic       gie_on     = ctrl_ff[CTRL_GIE];
  wire logic       wdt_on     = ctrl_ff[CTRL_WDT_EN];
  wire logic       wdt_slp_on = ctrl_ff[CTRL_WDT_SLEEP];
  wire logic [1:0] t1_src     = ctrl_ff[CTRL_T1SRC_HI:CTRL_T1SRC_LO];
  wire logic       in_run     = (state_ff == ST_RUN);
  wire logic       in_sleep   = (state_ff == ST_SLEEP);
  wire logic       in_next    = (state_ff == ST_NEXT);

  // Full-reset wake sources act the same whatever the power state
  wire logic master_clear_pin_hit = master_clear_pin & ctrl_ff[CTRL_MASTER_CLEAR_PIN_EN];   // [R10]
  wire logic bor_hit  = brownout_reset & ctrl_ff[CTRL_BOR_EN];      // [R10]
  wire logic full_rst = master_clear_pin_hit | bor_hit;                         // [R12]

  // Watchdog counting: awake when enabled, asleep only if also enabled for sleep
  wire logic wdt_count  = lf_tick & wdt_on & (in_sleep ? wdt_slp_on : 1'b1);   // [R02]
  wire logic wdt_expire = wdt_count & (wdt_cnt_ff == WDT_W'(WDT_LIMIT - 1));

  // Sleep entry only from the sleep instruction while running
  wire logic enter_sleep = in_run & sleep_exec & ~full_rst;         // [R01]
  // Resume wake: enabled interrupt or watchdog expiry in sleep
  wire logic wake_int    = in_sleep & wk.wake_int;                  // [R11] [R19]
  wire logic wake_wdt    = in_sleep & wdt_expire;                   // [R11]
  wire logic wake_resume = (wake_int | wake_wdt) & ~full_rst;       // [R12]
  wire logic vector_now  = in_next & instr_retired & gie_on & wk.wake_int;

  // State transitions
  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      ST_RUN: begin
        if (enter_sleep) begin
          nxt_state = ST_SLEEP;
        end
      end
      ST_SLEEP: begin
        if (full_rst) begin
          nxt_state = ST_RUN;                                     // [R12]
        end else if (wake_resume) begin
          nxt_state = ST_NEXT;                                    // [R19]
        end
      end
      ST_NEXT: begin
        // The prefetched instruction retires before any vectoring
        if (full_rst || instr_retired) begin
          nxt_state = ST_RUN;                                     // [R15] [R16]
        end
      end
      default: nxt_state = ST_RUN;
    endcase
  end

  always_ff @(posedge clk or negedge srst_n) begin
    if (!srst_n) begin
      state_ff <= ST_RUN;
    end else if (ce) begin
      state_ff <= nxt_state;
    end
  end

  // APB decode; the slave answers in the first access cycle
  wire logic setup_ph  = psel & ~penable;
  wire logic access_ph = psel & penable;
  wire logic hit_ctrl  = (paddr == OFF_CTRL);
  wire logic hit_stat  = (paddr == OFF_STATUS);
  wire logic hit_wken  = (paddr == OFF_WAKE_EN);
  wire logic hit_ists  = (paddr == OFF_IRQ_STS);
  wire logic hit_imsk  = (paddr == OFF_IRQ_MASK);
  wire logic hit_wdt   = (paddr == OFF_WDT_CNT);
  wire logic hit_any   = hit_ctrl | hit_stat | hit_wken | hit_ists | hit_imsk | hit_wdt;
  wire logic wr_go     = access_ph & pwrite & ce;
  wire logic wr_ctrl   = wr_go & hit_ctrl;
  wire logic wr_wken   = wr_go & hit_wken;
  wire logic wr_ists   = wr_go & hit_ists;
  wire logic wr_imsk   = wr_go & hit_imsk;

  assign pready  = 1'b1;
  assign pslverr = access_ph & ~hit_any;

  // Read mux; unmapped reads return zero
  wire logic [DATA_W-1:0] status_word = DATA_W'({in_next, in_sleep, to_flag_ff, pd_flag_ff});
  logic [DATA_W-1:0] rd_mux;
  always_comb begin
    rd_mux = '0;
    if (hit_ctrl) rd_mux = DATA_W'(ctrl_ff);
    if (hit_stat) rd_mux = status_word;
    if (hit_wken) rd_mux = DATA_W'(wake_en_ff);
    if (hit_ists) rd_mux = DATA_W'(irq_sts_ff);
    if (hit_imsk) rd_mux = DATA_W'(irq_mask_ff);
    if (hit_wdt)  rd_mux = DATA_W'(wdt_cnt_ff);
  end

  // Read data is captured in the setup cycle so prdata comes from a flop
  always_ff @(posedge clk or negedge srst_n) begin
    if (!srst_n) begin
      prdata_ff <= '0;
    end else if (ce && setup_ph) begin
      prdata_ff <= pwrite ? '0 : rd_mux;
    end
  end
  assign prdata = prdata_ff;

  // Software-written configuration
  always_ff @(posedge clk or negedge srst_n) begin
    if (!srst_n) begin
      ctrl_ff     <= CTRL_RST;
      wake_en_ff  <= '0;
      irq_mask_ff <= EV_RST;
    end else begin
      if (wr_ctrl) ctrl_ff     <= pwdata[CTRL_W-1:0];
      if (wr_wken) wake_en_ff  <= pwdata[N_INT-1:0];
      if (wr_imsk) irq_mask_ff <= pwdata[EV_W-1:0];
    end
  end

  // Core status flags; power-down flag set again only by power-on reset
  always_ff @(posedge clk or negedge srst_n) begin
    if (!srst_n) begin
      pd_flag_ff <= PD_RST;
      to_flag_ff <= TO_RST;
    end else if (ce) begin
      if (enter_sleep) begin
        pd_flag_ff <= 1'b0;                                       // [R03]
        to_flag_ff <= 1'b1;                                       // [R04]
      end else if (wdt_expire) begin
        to_flag_ff <= 1'b0;
      end
    end
  end

  // Watchdog counter, cleared on sleep entry, on any exit and on expiry
  wire logic wdt_clear = enter_sleep | (in_sleep & (nxt_state != ST_SLEEP)) | wdt_expire;
  always_ff @(posedge clk or negedge srst_n) begin
    if (!srst_n) begin
      wdt_cnt_ff <= '0;
    end else if (ce) begin
      if (wdt_clear) begin
        wdt_cnt_ff <= '0;                                         // [R02] [R18]
      end else if (wdt_count) begin
        wdt_cnt_ff <= wdt_cnt_ff + WDT_W'(1);
      end
    end
  end

  // Prefetch, vectoring and reset request pulses
  always_ff @(posedge clk or negedge srst_n) begin
    if (!srst_n) begin
      prefetch_ff      <= 1'b0;
      prefetch_addr_ff <= '0;
      isr_call_ff      <= 1'b0;
      dev_rst_ff       <= 1'b0;
      wdt_rst_ff       <= 1'b0;
    end else if (ce) begin
      prefetch_ff <= enter_sleep;                                 // [R13]
      if (enter_sleep) begin
        prefetch_addr_ff <= cpu_pc + PC_W'(1);                    // [R13]
      end
      isr_call_ff <= vector_now;                                  // [R16]
      dev_rst_ff  <= full_rst;                                    // [R12]
      wdt_rst_ff  <= wdt_expire & ~in_sleep;                      // [R12]
    end
  end
  assign prefetch_req       = prefetch_ff;
  assign prefetch_addr      = prefetch_addr_ff;
  assign isr_call           = isr_call_ff;
  assign device_reset_req   = dev_rst_ff;
  assign watchdog_reset_req = wdt_rst_ff;

  // CPU clock gate follows the state flops, so it restarts on the wake edge
  assign cpu_clk_en = ~in_sleep;                                  // [R05] [R19]

  // Clocks that survive sleep
  assign low_freq_internal_osc_run = 1'b1;                        // [R06]
  assign timer1_run = ~in_sleep | (t1_src != T1SRC_SYS);          // [R07]
  assign adc_run    = ~in_sleep | ctrl_ff[CTRL_ADC_RC];           // [R08]

  // Pin drive follows the core when awake and freezes while asleep
  always_ff @(posedge clk or negedge srst_n) begin
    if (!srst_n) begin
      pin_out_ff <= '0;
      pin_oe_ff  <= '0;
    end else if (ce && !in_sleep) begin
      pin_out_ff <= pin_out_in;                                   // [R09]
      pin_oe_ff  <= pin_oe_in;                                    // [R09]
    end
  end
  assign pin_out = pin_out_ff;
  assign pin_oe  = pin_oe_ff;

  // Sticky events; a new event wins over a write-one clear in the same cycle
  wire logic [EV_W-1:0] ev_set = {full_rst, wake_wdt & ~full_rst,
                                  wake_int & ~wake_wdt & ~full_rst, enter_sleep};
  wire logic [EV_W-1:0] ev_clr = wr_ists ? pwdata[EV_W-1:0] : '0;
  always_ff @(posedge clk or negedge srst_n) begin
    if (!srst_n) begin
      irq_sts_ff <= EV_RST;
    end else if (ce) begin
      irq_sts_ff <= (irq_sts_ff & ~ev_clr) | ev_set;
    end
  end
  assign irq = |(irq_sts_ff & irq_mask_ff);

endmodule : sleep_wake_controller

// >>> sleep_wake_controller_properties.sv
// Port-level properties of the sleep and wake controller
`timescale 1ns/1ps
module sleep_wake_props #(
  parameter int PC_W  = 15,
  parameter int PIN_W = 8
) (
  input wire logic             clk,
  input wire logic             rstn,
  input wire logic             sleep_exec,
  input wire logic [PC_W-1:0]  cpu_pc,
  input wire logic             instr_retired,
  input wire logic             cpu_clk_en,
  input wire logic             prefetch_req,
  input wire logic [PC_W-1:0]  prefetch_addr,
  input wire logic             isr_call,
  input wire logic             master_clear_pin,
  input wire logic             brownout_reset,
  input wire logic             device_reset_req,
  input wire logic             watchdog_reset_req,
  input wire logic             low_freq_internal_osc_run,
  input wire logic [PIN_W-1:0] pin_out,
  input wire logic [PIN_W-1:0] pin_oe
);
  // One clock domain, so one clocking and one disable serve every property
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  chk_entry_cause: assert property ($fell(cpu_clk_en) |-> $past(sleep_exec))
    else $error("CPU clock gated without a sleep command");
  chk_prefetch_next: assert property ($fell(cpu_clk_en) |-> prefetch_req &&
    prefetch_addr == PC_W'($past(cpu_pc) + 1)) else $error("bad prefetch at sleep entry");
  chk_prefetch_pulse: assert property (prefetch_req |=> !prefetch_req)
    else $error("prefetch request longer than one cycle");
  chk_pins_frozen: assert property (!cpu_clk_en && !$past(cpu_clk_en) |->
    $stable(pin_out) && $stable(pin_oe)) else $error("pin drive moved while asleep");
  chk_lfosc_alive: assert property (!cpu_clk_en |-> low_freq_internal_osc_run)
    else $error("low frequency oscillator stopped in sleep");
  // Allow one or two cycles of registering between the pin and the request
  chk_reset_cause: assert property (device_reset_req |->
    $past(master_clear_pin || brownout_reset) || $past(master_clear_pin || brownout_reset, 2))
    else $error("device reset without a reset source");
  chk_reset_runs: assert property (device_reset_req |-> cpu_clk_en)
    else $error("CPU clock off during device reset");
  chk_isr_after: assert property (isr_call |-> $past(instr_retired) || $past(instr_retired, 2))
    else $error("handler call before next instruction retired");
  chk_isr_pulse: assert property (isr_call |=> !isr_call)
    else $error("handler call longer than one cycle");
  chk_wdt_awake: assert property (watchdog_reset_req |-> $past(cpu_clk_en))
    else $error("watchdog reset requested from sleep");

  cover property ($fell(cpu_clk_en));
  cover property (isr_call);
  cover property (device_reset_req && $past(!cpu_clk_en));
endmodule : sleep_wake_props

bind sleep_wake_controller sleep_wake_props #(.PC_W(PC_W), .PIN_W(PIN_W)) sleep_wake_props_inst (
  .clk, .rstn, .sleep_exec, .cpu_pc, .instr_retired, .cpu_clk_en, .prefetch_req,
  .prefetch_addr, .isr_call, .master_clear_pin, .brownout_reset, .device_reset_req,
  .watchdog_reset_req, .low_freq_internal_osc_run, .pin_out, .pin_oe);

// >>> core_model.sv
// Behavioural CPU core that issues sleep and retires the instruction after it
`timescale 1ns/1ps
module core_model (
  input  wire logic        clk,
  input  wire logic        cpu_clk_en,
  input  wire logic        go,
  input  wire logic [3:0]  lag,
  output logic             sleep_exec,
  output logic [14:0]      cpu_pc,
  output logic             instr_retired
);
  logic       was_on = 1'b1;
  logic [4:0] cnt    = 5'h00;

  initial begin
    sleep_exec = 1'b0;
    cpu_pc = 15'h7FF0;
    instr_retired = 1'b0;
  end

  // A gated core advances nothing; the retire comes lag plus two cycles after the wake edge
  always @(posedge clk) begin
    was_on <= cpu_clk_en;
    sleep_exec <= go & cpu_clk_en;
    if (cpu_clk_en) begin
      cpu_pc <= cpu_pc + 15'h1;
    end
    if (cpu_clk_en && !was_on) begin
      cnt <= {1'b0, lag} + 5'h01;
    end else if (cnt != 5'h00) begin
      cnt <= cnt - 5'h01;
    end
    instr_retired <= (cnt == 5'h01);
  end
endmodule : core_model

// >>> sleep_wake_controller_tb.sv
// Self-checking bench for the sleep and wake controller
`timescale 1ns/1ps
module sleep_wake_controller_tb;
  import sleep_pkg::*;
  logic clk = 1'b0, rstn = 1'b0, ce = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic go = 1'b0, lf_tick = 1'b0, master_clear_pin = 1'b0, brownout_reset = 1'b0;
  logic [7:0] paddr = 8'h00, int_flag = 8'h00, pin_out_in = 8'h00, pin_oe_in = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic [14:0] cpu_pc, prefetch_addr;
  logic [7:0] pin_out, pin_oe;
  logic [3:0] lag = 4'h0;
  logic pready, pslverr, err, sleep_exec, instr_retired, cpu_clk_en, prefetch_req, isr_call;
  logic device_reset_req, watchdog_reset_req, low_freq_internal_osc_run, timer1_run, adc_run, irq;
  int mismatches = 0, check_count = 0, cyc = 0, isr_seen = 0, rst_seen = 0, wdt_seen = 0;

  sleep_wake_controller #(.WDT_LIMIT(4)) sleep_wake_controller_inst (.clk, .rstn, .ce, .psel,
    .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .sleep_exec, .cpu_pc,
    .instr_retired, .cpu_clk_en, .prefetch_req, .prefetch_addr, .isr_call, .int_flag, .lf_tick,
    .master_clear_pin, .brownout_reset, .device_reset_req, .watchdog_reset_req,
    .low_freq_internal_osc_run, .timer1_run, .adc_run, .pin_out_in, .pin_oe_in, .pin_out,
    .pin_oe, .irq);
  core_model core_model_inst (.clk, .cpu_clk_en, .go, .lag, .sleep_exec, .cpu_pc, .instr_retired);

  always #50 clk = ~clk;

  // Handler-call and reset-request pulses are counted so that later checks cannot miss them
  always @(posedge clk) begin
    isr_seen <= isr_seen + (isr_call === 1'b1);
    rst_seen <= rst_seen + (device_reset_req === 1'b1);
    wdt_seen <= wdt_seen + (watchdog_reset_req === 1'b1);
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      mismatches++;
      give_verdict;
    end
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
    check_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("BAD %0t %s: got %h want %h", $time, what, seen, exp);
    end
  endtask : chk

  // Holds the request until pready is sampled high, then releases it
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp, input string what);
    apb(1'b0, a, 32'h0);
    chk(rd, exp, what);
  endtask : rdchk

  task automatic nap;
    @(posedge clk);
    go <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
    repeat (3) @(posedge clk);
  endtask : nap

  task automatic wait_on;
    for (int i = 0; i < 50 && cpu_clk_en !== 1'b1; i++) @(posedge clk);
  endtask : wait_on

  task automatic pin_pulse;
    @(posedge clk);
    master_clear_pin <= 1'b1;
    @(posedge clk);
    master_clear_pin <= 1'b0;
    repeat (4) @(posedge clk);
  endtask : pin_pulse

  task automatic t_regs;
    rdchk(OFF_STATUS, 32'h3, "status after reset");
    rdchk(8'h40, 32'h0, "unmapped read");
    chk(err, 1'b1, "unmapped error");
    $display("test regs done");
  endtask : t_regs

  task automatic t_int_wake;
    pin_out_in <= 8'hA5;
    pin_oe_in <= 8'h0F;
    apb(1'b1, OFF_WAKE_EN, 32'h4);
    apb(1'b1, OFF_IRQ_MASK, 32'h2);
    nap;
    chk(cpu_clk_en, 1'b0, "asleep");
    pin_out_in <= 8'h5A;
    pin_oe_in <= 8'hF0;
    rdchk(OFF_STATUS, 32'h6, "status asleep");
    for (int k = 0; k < 4; k++) begin
      apb(1'b1, OFF_CTRL, 32'((k << 5) | ((k & 1) << 7)));
      @(negedge clk);
      chk(timer1_run, k != 0, "timer1 keep-alive");
      chk(adc_run, k[0], "converter keep-alive");
    end
    apb(1'b1, OFF_CTRL, 32'h0);
    chk(pin_out, 8'hA5, "pin level held");
    chk(pin_oe, 8'h0F, "pin enable held");
    int_flag <= 8'h01;
    repeat (4) @(posedge clk);
    chk(cpu_clk_en, 1'b0, "disabled source ignored");
    int_flag <= 8'h05;
    wait_on;
    chk(cpu_clk_en, 1'b1, "woken by enabled source");
    int_flag <= 8'h00;
    repeat (8) @(posedge clk);
    chk(isr_seen, 0, "no vectoring");
    rdchk(OFF_IRQ_STS, 32'h3, "entry and wake events");
    chk(irq, 1'b1, "masked-in event raises irq");
    apb(1'b1, OFF_IRQ_STS, 32'h3);
    @(negedge clk);
    chk(irq, 1'b0, "cleared event drops irq");
    $display("test interrupt wake done");
  endtask : t_int_wake

  task automatic t_gie_wake;
    apb(1'b1, OFF_CTRL, 32'h1);
    lag <= 4'h4;
    nap;
    int_flag <= 8'h04;
    wait_on;
    repeat (10) @(posedge clk);
    int_flag <= 8'h00;
    chk(isr_seen, 1, "handler called once after resume");
    apb(1'b1, OFF_IRQ_STS, 32'hF);
    $display("test vectored wake done");
  endtask : t_gie_wake

  task automatic t_wdt_wake;
    apb(1'b1, OFF_CTRL, 32'h6);
    lag <= 4'h0;
    nap;
    rdchk(OFF_WDT_CNT, 32'h0, "watchdog cleared on entry");
    for (int i = 0; i < 8 && cpu_clk_en !== 1'b1; i++) begin
      @(posedge clk);
      lf_tick <= 1'b1;
      @(posedge clk);
      lf_tick <= 1'b0;
      repeat (2) @(posedge clk);
    end
    chk(cpu_clk_en, 1'b1, "woken by watchdog");
    rdchk(OFF_WDT_CNT, 32'h0, "watchdog cleared on wake");
    rdchk(OFF_IRQ_STS, 32'h5, "watchdog wake event");
    // Awake expiry must ask for a watchdog reset instead of a resume
    repeat (4) begin
      @(posedge clk);
      lf_tick <= 1'b1;
      @(posedge clk);
      lf_tick <= 1'b0;
    end
    repeat (2) @(posedge clk);
    chk(wdt_seen, 1, "watchdog reset while awake");
    apb(1'b1, OFF_CTRL, 32'h0);
    apb(1'b1, OFF_IRQ_STS, 32'hF);
    $display("test watchdog wake done");
  endtask : t_wdt_wake

  task automatic t_reset_wake;
    nap;
    pin_pulse;
    chk(cpu_clk_en, 1'b0, "disabled pin reset ignored");
    apb(1'b1, OFF_CTRL, 32'h8);
    pin_pulse;
    wait_on;
    chk(cpu_clk_en, 1'b1, "woken by pin reset");
    chk(rst_seen > 0, 1'b1, "device reset requested");
    // A sleep command while the clock enable is low must be lost
    ce <= 1'b0;
    nap;
    chk(cpu_clk_en, 1'b1, "no entry while frozen");
    ce <= 1'b1;
    $display("test reset wake done");
  endtask : t_reset_wake

  task automatic give_verdict;
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : give_verdict

  initial begin
    repeat (12) @(posedge clk);
    rstn <= 1'b1;
    repeat (3) @(posedge clk);
    t_regs;
    t_int_wake;
    t_gie_wake;
    t_wdt_wake;
    t_reset_wake;
    give_verdict;
  end
endmodule : sleep_wake_controller_tb
